// *** dv/lin_brk_monitor.sv ***
`timescale 1ns/1ps
module lin_brk_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // controls
    input wire logic uart_power_on,
    input wire logic tx_enable_bit,
    input wire logic rx_enable_bit,
    input wire logic [3:0] base_clock_sel,
    input wire logic [7:0] divisor_value,
    input wire logic break_rx_trigger_set,
    // status
    input wire logic break_rx_trigger,
    input wire logic break_rx_flag,
    input wire logic rx_done_irq,
    input wire logic [2:0] rx_error_status,
    input wire logic [7:0] rx_buffer_reg,
    input wire logic base_clk_tick,
    input wire logic [7:0] tx_count,
    input wire logic [7:0] rx_count
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_ERR_HOLD: assert property (rx_error_status == 3'h0)
        else $error("error flags moved");
    AST_BUF_HOLD: assert property (rx_buffer_reg == 8'hff)
        else $error("receive buffer loaded");
    AST_TX_STOP: assert property (!(uart_power_on && tx_enable_bit) [*2]
        |-> tx_count == 8'h00) else $error("tx counter runs");
    AST_RX_STOP: assert property (!(uart_power_on && rx_enable_bit) [*2]
        |-> rx_count == 8'h00) else $error("rx counter runs");
    AST_GATE: assert property (!uart_power_on [*2] |-> !base_clk_tick)
        else $error("base clock while off");
    AST_IRQ_PULSE: assert property (rx_done_irq |=> !rx_done_irq)
        else $error("irq too long");
    AST_IRQ_ARMED: assert property (rx_done_irq |-> $past(break_rx_trigger))
        else $error("irq while not armed");
    AST_IRQ_CLR: assert property (rx_done_irq |-> ##[0:1]
        (!break_rx_trigger && !break_rx_flag)) else $error("flags kept");
    AST_ARM: assert property ($rose(break_rx_trigger) |->
        $past(break_rx_trigger_set && uart_power_on && rx_enable_bit))
        else $error("trigger set unasked");
    // two cycle spacing is the tightest prescaler above sel 0
    AST_TICK: assert property (base_clk_tick && base_clock_sel != 4'h0
        && $stable(base_clock_sel) |=> !base_clk_tick) else $error("tick");
    AST_K_MAX: assert property ($stable(divisor_value) &&
        divisor_value >= 8'h08 |-> tx_count <= divisor_value
        && rx_count <= divisor_value) else $error("count above k");
    cover property (rx_done_irq);
    cover property ($rose(break_rx_flag));
    cover property (base_clk_tick && tx_count == divisor_value);
endmodule
bind uart_lin_break_and_baud_gen lin_brk_monitor u_lin_brk_monitor (
    .ref_clk, .rst, .uart_power_on, .tx_enable_bit, .rx_enable_bit,
    .base_clock_sel, .divisor_value, .break_rx_trigger_set,
    .break_rx_trigger, .break_rx_flag, .rx_done_irq, .rx_error_status,
    .rx_buffer_reg, .base_clk_tick, .tx_count, .rx_count);

// *** dv/lin_peer.sv ***
`timescale 1ns/1ps
module lin_peer (
    // clock
    input wire logic ref_clk,
    // line
    output logic serial_in_pin
);
    // idle high, as the pulled-up bus rests
    initial serial_in_pin = 1'b1;
    task automatic send_break(input int bits, input int bit_cycles);
        @(posedge ref_clk);
        serial_in_pin <= 1'b0;
        repeat (bits * bit_cycles) @(posedge ref_clk);
        serial_in_pin <= 1'b1;
    endtask
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic uart_power_on = 1'b0;
    logic tx_enable_bit = 1'b0;
    logic rx_enable_bit = 1'b0;
    logic [3:0] base_clock_sel = 4'h0;
    logic [7:0] divisor_value = 8'h08;
    logic break_rx_trigger_set = 1'b0;
    logic tx_buffer_write = 1'b0;
    logic tx_next_pending = 1'b0;
    logic serial_in_pin, break_rx_trigger, break_rx_flag, rx_done_irq;
    logic [2:0] rx_error_status;
    logic [7:0] rx_buffer_reg, tx_count, rx_count;
    logic base_clk_tick, tx_half_clk, rx_half_clk;
    int bad_count = 0;
    int comparisons = 0;
    int bitc, k, sel;
    int lens[$] = '{9, 12};
    initial forever #25 ref_clk = ~ref_clk;
    uart_lin_break_and_baud_gen u_uart_lin_break_and_baud_gen (.ref_clk,
        .rst, .uart_power_on, .tx_enable_bit, .rx_enable_bit,
        .base_clock_sel, .divisor_value, .break_rx_trigger_set,
        .tx_buffer_write, .tx_next_pending, .serial_in_pin,
        .break_rx_trigger, .break_rx_flag, .rx_done_irq, .rx_error_status,
        .rx_buffer_reg, .base_clk_tick, .tx_count, .rx_count,
        .tx_half_clk, .rx_half_clk);
    lin_peer u_lin_peer (.ref_clk, .serial_in_pin);
    task automatic give_verdict();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t bit %b want %b", $time, got, exp);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t byte %h want %h", $time, got, exp);
        end
    endtask
    task automatic run_break(input int bits);
        logic seen;
        seen = 1'b0;
        @(posedge ref_clk);
        break_rx_trigger_set <= 1'b1;
        @(posedge ref_clk);
        break_rx_trigger_set <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 check_bit(break_rx_trigger, 1'b1);
        fork
            u_lin_peer.send_break(bits, bitc);
            begin
                repeat (bitc * 5) @(posedge ref_clk);
                #1 check_bit(break_rx_flag, 1'b1);
            end
        join
        // bounded wait; a missing irq after a long break is a mismatch
        for (int n = 0; n < bitc * 3 && !seen; n++) begin
            @(posedge ref_clk);
            #1 seen = rx_done_irq;
        end
        check_bit(seen, 2 * bits > 21);
        if (!seen && 2 * bits > 21) give_verdict();
        repeat (2) @(posedge ref_clk);
        #1 check_bit(break_rx_trigger, 2 * bits <= 21);
        check_bit(break_rx_flag, 2 * bits <= 21);
        check_byte(rx_buffer_reg, 8'hff);
        check_byte({5'h00, rx_error_status}, 8'h00);
    endtask
    initial begin
        void'($urandom(32'h22a9));
        sel = $urandom_range(1, 0);
        k = $urandom_range(20, 8);
        bitc = 2 * k * (1 << sel);
        lens.push_back($urandom_range(16, 12));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1 check_byte(rx_buffer_reg, 8'hff);
        check_bit(break_rx_trigger, 1'b0);
        @(posedge ref_clk);
        base_clock_sel <= 4'(sel);
        divisor_value <= 8'(k);
        tx_next_pending <= 1'($urandom);
        @(posedge ref_clk);
        uart_power_on <= 1'b1;
        rx_enable_bit <= 1'b1;
        tx_enable_bit <= 1'b1;
        foreach (lens[i]) run_break(lens[i]);
        @(posedge ref_clk);
        tx_buffer_write <= 1'b1;
        @(posedge ref_clk);
        tx_buffer_write <= 1'b0;
        repeat (5) @(posedge ref_clk);
        #1 check_bit(tx_count != 8'h00, 1'b1);
        check_bit(tx_half_clk, 1'b0);
        @(posedge ref_clk);
        uart_power_on <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 check_byte(tx_count, 8'h00);
        check_byte(rx_count, 8'h00);
        check_bit(base_clk_tick, 1'b0);
        check_bit(rx_half_clk, 1'b0);
        give_verdict();
    end
endmodule

// *** hdl/lin_brk_defs.svh ***
`ifndef LIN_BRK_DEFS_SVH
`define LIN_BRK_DEFS_SVH
// base_clock_sel 0..10 divides ref_clk by 2**sel
`define SEL_MAX 4'ha
`define K_MIN 8'h08
// break accepted at 10.5 bit times (21 half periods) or more
`define BRK_MIN_HALVES 5'h15
`define RX_FRAME_HALVES 5'h14
`define TX_FRAME_HALVES 5'h16
`define STRETCH_TICKS 2'h2
`define RX_BUF_RESET 8'hff
`endif

// *** hdl/lin_brk_pkg.sv ***
package lin_brk_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_STRETCH} tx_state_t;
endpackage

// *** hdl/uart_lin_break_and_baud_gen.sv ***
// Operation
// R1: software sends zero byte, 8 bits, even parity
// R2: software sets break length select to 101
// R3: software scales divisor by 1.3 for break
// R4: break receive armed by trigger, power, enable
// R5: break receive detects start like normal
// R6: long break: irq, clear flag and trigger
// R7: break receive leaves error flags untouched
// R8: break receive never loads receive buffer
// R9: short break: no irq, stay armed
// R10: base clock gated by power bit
// R11: separate 8-bit tx and rx counters
// R12: tx counter zero unless power and enable
// R13: tx counter clears on first buffer write
// R14: back-to-back clears per frame, else runs
// R15: rx counter zero unless power and enable
// R16: rx counter runs from start for a frame
// R17: counter clock chosen by base_clock_sel
// R18: divisor_value sets division value k
// R19: bit rate is base clock over 2k
// R20: input accepted after two agreeing samples
// R21: start confirmed low after k base clocks
// R22: back-to-back stop bit stretched two clocks
// R23: counter reloads at k, toggles half clock
// R24: break width measured in half bits
// R25: break flag set while break in progress
`timescale 1ns/1ps
`include "lin_brk_defs.svh"
module uart_lin_break_and_baud_gen (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control bits
    input wire logic uart_power_on,
    input wire logic tx_enable_bit,
    input wire logic rx_enable_bit,
    input wire logic [3:0] base_clock_sel,
    input wire logic [7:0] divisor_value,
    input wire logic break_rx_trigger_set,
    input wire logic tx_buffer_write,
    input wire logic tx_next_pending,
    // serial line
    input wire logic serial_in_pin,
    // status
    output logic break_rx_trigger,
    output logic break_rx_flag,
    output logic rx_done_irq,
    output logic [2:0] rx_error_status,
    output logic [7:0] rx_buffer_reg,
    output logic base_clk_tick,
    output logic [7:0] tx_count,
    output logic [7:0] rx_count,
    output logic tx_half_clk,
    output logic rx_half_clk
);
    logic [10:0] pre_r;
    logic tick_r;
    logic [1:0] pin_sync_r;
    logic s1_r, s2_r, filt_r;
    logic [7:0] tx_cnt_r, rx_cnt_r;
    logic tx_hc_r, rx_hc_r;
    logic [4:0] rx_halves_r, tx_halves_r;
    logic [4:0] low_halves_r;
    logic [1:0] stretch_r;
    logic trig_r, flag_r, irq_r;
    lin_brk_pkg::rx_state_t rx_st_r;
    lin_brk_pkg::tx_state_t tx_st_r;
    logic [2:0] err_r;
    logic [7:0] rxbuf_r;

    // counter top test, shared by both counters and the start check
    function automatic logic at_top(input logic [7:0] cnt,
                                    input logic [7:0] kk);
        at_top = cnt == 8'(kk - 8'h01);
    endfunction

    // base clock: ref_clk tick every 2**sel cycles, held off unpowered
    wire [3:0] sel = (base_clock_sel > `SEL_MAX) ? `SEL_MAX : base_clock_sel;
    wire [10:0] pre_mask = 11'((11'h001 << sel) - 11'h001);
    wire tick_nxt = uart_power_on && ((pre_r & pre_mask) == pre_mask); // R10 R17
    // k below the legal floor is clamped so the divider never stalls
    wire [7:0] k = (divisor_value < `K_MIN) ? `K_MIN : divisor_value; // R18 R19
    wire tx_run = uart_power_on && tx_enable_bit; // R12
    wire rx_run = uart_power_on && rx_enable_bit; // R15
    wire tx_wrap = tick_r && at_top(tx_cnt_r, k); // R23
    wire rx_wrap = tick_r && at_top(rx_cnt_r, k); // R23
    wire fall = tick_r && !filt_r && (s1_r == s2_r) && !s2_r;
    wire rx_active = rx_st_r != lin_brk_pkg::RX_IDLE;
    wire in_break = trig_r && rx_run; // R4
    wire frame_end = rx_wrap && rx_st_r == lin_brk_pkg::RX_DATA &&
                     rx_halves_r == `RX_FRAME_HALVES;
    wire brk_ok = low_halves_r >= `BRK_MIN_HALVES; // R24
    wire tx_frame_end = tx_wrap && tx_halves_r == `TX_FRAME_HALVES;
    // stop bit: line back high once a full frame has passed
    wire stop_seen = rx_st_r == lin_brk_pkg::RX_DATA && rx_wrap && filt_r &&
                     rx_halves_r >= `RX_FRAME_HALVES;

    always_ff @(posedge ref_clk) begin
        if (rst || !uart_power_on) begin
            pre_r <= 11'h000;
        end else begin
            pre_r <= 11'(pre_r + 11'h001);
        end
        tick_r <= rst ? 1'b0 : tick_nxt;
    end

    // pin sync, then two-sample agreement filter on base ticks
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_sync_r <= 2'b11;
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            filt_r <= 1'b1;
        end else begin
            pin_sync_r <= {pin_sync_r[0], serial_in_pin};
            if (tick_r) begin
                s1_r <= pin_sync_r[1];
                s2_r <= s1_r;
                if (s1_r == s2_r) begin
                    filt_r <= s2_r; // R20
                end
            end
        end
    end

    // transmit counter
    always_ff @(posedge ref_clk) begin
        if (rst || !tx_run) begin
            tx_cnt_r <= 8'h00; // R12
            tx_hc_r <= 1'b0;
            tx_halves_r <= 5'h00;
            stretch_r <= 2'h0;
            tx_st_r <= lin_brk_pkg::TX_IDLE;
        end else if (tx_buffer_write && tx_st_r == lin_brk_pkg::TX_IDLE) begin
            tx_cnt_r <= 8'h00; // R13
            tx_hc_r <= 1'b0;
            tx_halves_r <= 5'h00;
            tx_st_r <= lin_brk_pkg::TX_SEND;
        end else if (tx_st_r == lin_brk_pkg::TX_STRETCH) begin
            // extra base clocks hold the stop bit before the next frame
            if (tick_r) begin
                stretch_r <= 2'(stretch_r + 2'h1);
                if (stretch_r == `STRETCH_TICKS - 2'h1) begin
                    stretch_r <= 2'h0;
                    tx_cnt_r <= 8'h00; // R14
                    tx_hc_r <= 1'b0;
                    tx_halves_r <= 5'h00;
                    tx_st_r <= lin_brk_pkg::TX_SEND;
                end
            end
        end else if (tx_frame_end && tx_st_r == lin_brk_pkg::TX_SEND) begin
            if (tx_next_pending) begin
                tx_st_r <= lin_brk_pkg::TX_STRETCH; // R22
            end else begin
                tx_cnt_r <= 8'h00;
                tx_hc_r <= !tx_hc_r;
                tx_st_r <= lin_brk_pkg::TX_IDLE; // R14
            end
        end else if (tick_r) begin
            tx_cnt_r <= tx_wrap ? 8'h00 : 8'(tx_cnt_r + 8'h01); // R11 R23
            if (tx_wrap) begin
                tx_hc_r <= !tx_hc_r; // R19
                if (tx_halves_r != 5'h1f) begin
                    tx_halves_r <= 5'(tx_halves_r + 5'h01);
                end
            end
        end
    end

    // receive counter and break detection
    always_ff @(posedge ref_clk) begin
        if (rst || !rx_run) begin
            rx_cnt_r <= 8'h00; // R15
            rx_hc_r <= 1'b0;
            rx_halves_r <= 5'h00;
            low_halves_r <= 5'h00;
            rx_st_r <= lin_brk_pkg::RX_IDLE;
        end else begin
            unique case (rx_st_r)
                lin_brk_pkg::RX_IDLE: begin
                    if (fall) begin
                        rx_cnt_r <= 8'h00; // R5 R16
                        rx_st_r <= lin_brk_pkg::RX_START;
                    end
                end
                lin_brk_pkg::RX_START: begin
                    if (tick_r) begin
                        rx_cnt_r <= 8'(rx_cnt_r + 8'h01);
                        if (at_top(rx_cnt_r, k)) begin
                            rx_cnt_r <= 8'h00;
                            rx_hc_r <= 1'b1;
                            rx_halves_r <= 5'h01;
                            low_halves_r <= 5'h01;
                            rx_st_r <= filt_r ? lin_brk_pkg::RX_IDLE
                                              : lin_brk_pkg::RX_DATA; // R21
                        end
                    end
                end
                lin_brk_pkg::RX_DATA: begin
                    if (tick_r) begin
                        rx_cnt_r <= rx_wrap ? 8'h00 : 8'(rx_cnt_r + 8'h01);
                    end
                    if (rx_wrap) begin
                        rx_hc_r <= !rx_hc_r; // R23
                        if (rx_halves_r != 5'h1f) begin
                            rx_halves_r <= 5'(rx_halves_r + 5'h01);
                        end
                        if (!filt_r && low_halves_r != 5'h1f) begin
                            low_halves_r <= 5'(low_halves_r + 5'h01); // R24
                        end
                    end
                    // a break holds the line low past the frame, so the
                    // stop bit may come long after the normal frame end
                    if ((frame_end && (filt_r || !in_break)) ||
                        stop_seen) begin
                        rx_cnt_r <= 8'h00; // R16
                        rx_st_r <= lin_brk_pkg::RX_IDLE;
                    end
                end
                default: rx_st_r <= lin_brk_pkg::RX_IDLE;
            endcase
        end
    end

    wire brk_done = in_break && stop_seen && brk_ok; // R6
    wire norm_done = !in_break && frame_end;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= brk_done || norm_done; // R6 R9
        end
    end

    // a software arm in the same cycle as the clear wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trig_r <= 1'b0;
        end else if (break_rx_trigger_set) begin
            trig_r <= 1'b1; // R4
        end else if (brk_done) begin
            trig_r <= 1'b0; // R6
        end
    end

    // the clear must beat the in-progress set, which is also true then
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else if (break_rx_trigger_set) begin
            flag_r <= 1'b1; // R25
        end else if (brk_done) begin
            flag_r <= 1'b0; // R6
        end else if (in_break && rx_active) begin
            flag_r <= 1'b1; // R25 R9
        end
    end

    // error flags belong to normal framing and are never touched here
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            err_r <= 3'b000;
            rxbuf_r <= `RX_BUF_RESET;
        end else begin
            err_r <= err_r; // R7
            rxbuf_r <= rxbuf_r; // R8
        end
    end

    assign rx_error_status = err_r;
    assign rx_buffer_reg = rxbuf_r;
    assign break_rx_trigger = trig_r;
    assign break_rx_flag = flag_r;
    assign rx_done_irq = irq_r;
    assign base_clk_tick = tick_r;
    assign tx_count = tx_cnt_r;
    assign rx_count = rx_cnt_r;
    assign tx_half_clk = tx_hc_r;
    assign rx_half_clk = rx_hc_r;
endmodule
